// *** rtl/lfd_defs.vh ***
`ifndef LFD_DEFS_VH
`define LFD_DEFS_VH

// Nominal rate of the crystal time base, in Hz.
`define LFD_TB_NOMINAL_HZ 32768

// First stage divides the time base by 256: one toggle bit and seven count bits.
`define LFD_PRE_DIV 256
`define LFD_PRE_BITS 7
`define LFD_PRE_LAST 7'h7f

// One-second frame of the intermediate pulse train.
`define LFD_FRAME_LEN 8'h80
`define LFD_FRAME_BITS 7

// Intermediate pulses removed per second in each mode.
`define LFD_DROP_60 8'h08
`define LFD_DROP_50 8'h1c

// Line-frequency to 10 Hz stage: modulus and count of high steps per mode.
`define LFD_DIV_60 4'h6
`define LFD_HIGH_60 4'h3
`define LFD_DIV_50 4'h5
`define LFD_HIGH_50 4'h2

// 10 Hz to 1 Hz stage.
`define LFD_DIV_SEC 4'ha
`define LFD_HIGH_SEC 4'h5

// Divider counter width.
`define LFD_DIV_BITS 4

`endif

// *** rtl/lfd_mod_div.v ***
`timescale 1ns/10ps
`include "lfd_defs.vh"

// Modulo divider stepped by a one-cycle enable. The wave is high for the
// first high_in steps of each period and a wrap pulse marks each new period.
module lfd_mod_div #(
    parameter WIDTH = `LFD_DIV_BITS
) (
    // Clock and clear
    input wire clk_in,
    input wire clr_in,
    // Step control
    input wire step_in,
    input wire [WIDTH-1:0] modulus_in,
    input wire [WIDTH-1:0] high_in,
    // Results
    output reg wave_out,
    output reg wrap_out
);

    reg [WIDTH-1:0] cnt_q;
    reg [WIDTH-1:0] cnt_d;
    wire last_w;

    assign last_w = (cnt_q == (modulus_in - {{(WIDTH-1){1'b0}}, 1'b1}));

    always @* begin
        cnt_d = cnt_q;
        if (step_in) begin
            if (last_w) begin
                cnt_d = {WIDTH{1'b0}};
            end else begin
                cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge clk_in) begin
        if (clr_in) begin
            cnt_q <= {WIDTH{1'b0}};
            wave_out <= 1'b1;
            wrap_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wave_out <= (cnt_d < high_in);
            wrap_out <= step_in & last_w;
        end
    end

endmodule

// *** rtl/lfd_top.v ***
`timescale 1ns/10ps
`include "lfd_defs.vh"

module lfd_top (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Crystal time base, sampled on the core clock
    input wire time_base_input_in,
    // Decoded line-frequency select
    input wire sel_60hz_in,
    input wire sel_float_in,
    // Divided outputs and hold flag
    output reg line_freq_out,
    output reg ten_hz_out,
    output reg one_hz_out,
    output reg hold_active_out
);

    // ************************************************************
    // Time base edge detection
    // ************************************************************

    reg tb_q;
    wire tb_rise_w;

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            tb_q <= 1'b0;
        end else begin
            tb_q <= time_base_input_in;
        end
    end

    // Each rising edge of the crystal input advances the chain by one count.
    assign tb_rise_w = time_base_input_in & ~tb_q;

    // ************************************************************
    // Mode decode and chain clear
    // ************************************************************

    reg mode_60_q;
    reg was_float_q;
    wire mode_change_w;
    wire chain_clr_w;

    // The select pin arrives already decoded into a level and a float flag.
    assign mode_change_w = ~sel_float_in & (sel_60hz_in != mode_60_q);
    // Floating select or a mode switch restarts every stage after the toggle.
    assign chain_clr_w = rst_in | sel_float_in | mode_change_w;

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            mode_60_q <= 1'b1;
            was_float_q <= 1'b0;
        end else begin
            was_float_q <= sel_float_in;
            if (!sel_float_in) begin
                mode_60_q <= sel_60hz_in;
            end
        end
    end

    // ************************************************************
    // Divide by 256
    // ************************************************************

    reg toggle_q;
    reg [`LFD_PRE_BITS-1:0] pre_q;
    wire pulse_128_w;

    // The toggle stage keeps running while the rest of the chain is held.
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            toggle_q <= 1'b0;
        end else if (tb_rise_w) begin
            toggle_q <= ~toggle_q;
        end
    end

    always @(posedge core_clk_in) begin
        if (chain_clr_w) begin
            pre_q <= {`LFD_PRE_BITS{1'b0}};
        end else if (tb_rise_w && toggle_q) begin
            pre_q <= pre_q + {{(`LFD_PRE_BITS-1){1'b0}}, 1'b1};
        end
    end

    // One pulse every 256 time base edges.
    assign pulse_128_w = tb_rise_w & toggle_q & (pre_q == `LFD_PRE_LAST) & ~chain_clr_w;

    // ************************************************************
    // Pulse removal across the one-second frame
    // ************************************************************

    reg [`LFD_FRAME_BITS-1:0] frame_q;
    reg [`LFD_FRAME_BITS-1:0] acc_q;
    reg [`LFD_FRAME_BITS-1:0] acc_d;
    reg drop_w;
    reg [`LFD_FRAME_BITS:0] sum_w;
    wire [`LFD_FRAME_BITS:0] drop_cnt_w;
    wire keep_w;

    // Per-mode count of intermediate pulses removed each second.
    assign drop_cnt_w = mode_60_q ? `LFD_DROP_60 : `LFD_DROP_50;

    // A phase accumulator adds the drop count once per pulse and removes a
    // pulse on each overflow, so removals are spaced evenly and the total per
    // 128 pulses is exact. The accumulator returns to zero every frame.
    always @* begin
        sum_w = {1'b0, acc_q} + drop_cnt_w;
        drop_w = (sum_w >= `LFD_FRAME_LEN);
        if (drop_w) begin
            acc_d = sum_w[`LFD_FRAME_BITS-1:0];
        end else begin
            acc_d = sum_w[`LFD_FRAME_BITS-1:0];
        end
    end

    always @(posedge core_clk_in) begin
        if (chain_clr_w) begin
            acc_q <= {`LFD_FRAME_BITS{1'b0}};
            frame_q <= {`LFD_FRAME_BITS{1'b0}};
        end else if (pulse_128_w) begin
            frame_q <= frame_q + {{(`LFD_FRAME_BITS-1){1'b0}}, 1'b1};
            // Forcing zero at the frame end keeps the pattern locked to the second.
            if (frame_q == `LFD_PRE_LAST) begin
                acc_q <= {`LFD_FRAME_BITS{1'b0}};
            end else begin
                acc_q <= acc_d;
            end
        end
    end

    assign keep_w = pulse_128_w & ~drop_w;

    // ************************************************************
    // Halving stage: line-frequency output
    // ************************************************************

    wire line_step_w;

    // A kept pulse that takes the line output from low to high steps the next divider.
    assign line_step_w = keep_w & ~line_freq_out;

    always @(posedge core_clk_in) begin
        if (chain_clr_w) begin
            line_freq_out <= 1'b0;
        end else if (keep_w) begin
            line_freq_out <= ~line_freq_out;
        end
    end

    // ************************************************************
    // Line frequency to 10 Hz and 10 Hz to 1 Hz
    // ************************************************************

    wire [`LFD_DIV_BITS-1:0] ten_mod_w;
    wire [`LFD_DIV_BITS-1:0] ten_high_w;
    wire ten_wave_w;
    wire ten_wrap_w;
    wire one_wave_w;

    // Six steps with three high in 60 Hz mode, five with two high in 50 Hz mode.
    assign ten_mod_w = mode_60_q ? `LFD_DIV_60 : `LFD_DIV_50;
    assign ten_high_w = mode_60_q ? `LFD_HIGH_60 : `LFD_HIGH_50;

    lfd_mod_div #(
        .WIDTH(`LFD_DIV_BITS)
    ) u_ten_div (
        .clk_in(core_clk_in),
        .clr_in(chain_clr_w),
        .step_in(line_step_w),
        .modulus_in(ten_mod_w),
        .high_in(ten_high_w),
        .wave_out(ten_wave_w),
        .wrap_out(ten_wrap_w)
    );

    // Each new 10 Hz period steps the seconds divider, five of ten high.
    lfd_mod_div #(
        .WIDTH(`LFD_DIV_BITS)
    ) u_sec_div (
        .clk_in(core_clk_in),
        .clr_in(chain_clr_w),
        .step_in(ten_wrap_w),
        .modulus_in(`LFD_DIV_SEC),
        .high_in(`LFD_HIGH_SEC),
        .wave_out(one_wave_w),
        .wrap_out()
    );

    // ************************************************************
    // Output registers
    // ************************************************************

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            ten_hz_out <= 1'b1;
            one_hz_out <= 1'b1;
            hold_active_out <= 1'b0;
        end else begin
            ten_hz_out <= ten_wave_w;
            one_hz_out <= one_wave_w;
            hold_active_out <= sel_float_in | was_float_q;
        end
    end

endmodule

// *** bench/lfd_top_sva.sv ***
`timescale 1ns/10ps
// ****
// Port checks.
// ****
module lfd_sva (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Inputs
    input wire time_base_input_in,
    input wire sel_60hz_in,
    input wire sel_float_in,
    // Outputs
    input wire line_freq_out,
    input wire ten_hz_out,
    input wire one_hz_out,
    input wire hold_active_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    reg [3:0] tb_q;
    reg [3:0] ln_q;
    reg [3:0] tn_q;
    wire [2:0] tb_e = tb_q[2:0] & ~tb_q[3:1];
    wire [2:0] ln_e = ln_q[2:0] & ~ln_q[3:1];
    wire [2:0] tn_e = tn_q[2:0] & ~tn_q[3:1];
    always @(posedge core_clk_in) begin
        tb_q <= {tb_q[2:0], time_base_input_in};
        ln_q <= {ln_q[2:0], line_freq_out};
        tn_q <= {tn_q[2:0], ten_hz_out};
    end
    AST_LINE_SRC: assert property ($rose(line_freq_out) |-> |tb_e)
        else $error("line rose without a time base edge");
    AST_TEN_SRC: assert property ($fell(ten_hz_out) |-> |ln_e)
        else $error("ten hz fell without a line rise");
    AST_ONE_SRC: assert property ($fell(one_hz_out) |-> |tn_e)
        else $error("one hz fell without a ten hz wrap");
    AST_FLT_LINE: assert property (sel_float_in |=> !line_freq_out)
        else $error("line not held while floating");
    AST_FLT_DIV: assert property (sel_float_in [*2] |=> ten_hz_out && one_hz_out)
        else $error("dividers not held while floating");
    AST_HOLD_ON: assert property (sel_float_in |=> hold_active_out)
        else $error("hold flag missing");
    AST_HOLD_OFF: assert property (!sel_float_in && !$past(sel_float_in)
        && !$past(sel_float_in, 2) |-> !hold_active_out) else $error("hold flag stuck");
    AST_MODE_CLR: assert property ($changed(sel_60hz_in) && !sel_float_in
        |-> ##3 (!line_freq_out && ten_hz_out && one_hz_out)) else $error("no restart");
    cover property ($rose(line_freq_out));
    cover property ($fell(one_hz_out));
    cover property ($fell(hold_active_out));
endmodule

bind lfd_top lfd_sva u_sva (.core_clk_in, .rst_in, .time_base_input_in, .sel_60hz_in,
    .sel_float_in, .line_freq_out, .ten_hz_out, .one_hz_out, .hold_active_out);

// *** bench/lfd_xtal.sv ***
`timescale 1ns/10ps
// ****
// Crystal time base model, halted while not running.
// ****
module lfd_xtal (
    // Clock and control
    input wire core_clk_in,
    input wire run_in,
    input wire [3:0] half_in,
    // Time base and its rising edge count
    output reg time_base_out = 1'b0,
    output reg [31:0] edges_out = 32'h0
);
    reg [3:0] cnt_q = 4'h0;
    always @(posedge core_clk_in) begin
        if (run_in) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= half_in) begin
                cnt_q <= 4'h0;
                time_base_out <= ~time_base_out;
                edges_out <= edges_out + {31'h0, ~time_base_out};
            end
        end
    end
endmodule

// *** bench/test_line_frequency_divider.sv ***
`timescale 1ns/10ps
// ****
// Bench.
// ****
module test_line_frequency_divider;
    reg core_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg sel_60hz_in = 1'b1;
    reg sel_float_in = 1'b0;
    reg run_q = 1'b0;
    reg [3:0] half_q = 4'h1;
    wire time_base_input_in, line_freq_out, ten_hz_out, one_hz_out, hold_active_out;
    wire [31:0] edges;
    integer error_cnt = 0, total_checks = 0;
    integer lt = 0, tt = 0, ot = 0, th = 0, oh = 0, cyc = 0;
    reg lp = 1'b0, tp = 1'b0, op = 1'b0;
    always #4 core_clk_in = ~core_clk_in;
    lfd_xtal xtal (.core_clk_in, .run_in(run_q), .half_in(half_q),
        .time_base_out(time_base_input_in), .edges_out(edges));
    lfd_top dut (.core_clk_in, .rst_in, .time_base_input_in, .sel_60hz_in, .sel_float_in,
        .line_freq_out, .ten_hz_out, .one_hz_out, .hold_active_out);
    always @(posedge core_clk_in) begin
        {lp, tp, op} <= {line_freq_out, ten_hz_out, one_hz_out};
        lt <= lt + (line_freq_out !== lp);
        tt <= tt + (ten_hz_out !== tp);
        ot <= ot + (one_hz_out !== op);
        th <= th + (ten_hz_out === 1'b1);
        oh <= oh + (one_hz_out === 1'b1);
        cyc <= cyc + 1;
    end
    task check(input [31:0] seen, input [31:0] exp, input string what);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
            end
        end
    endtask
    task run(input integer n);
        integer t;
        begin
            t = edges + n;
            run_q <= 1'b1;
            while (edges < t) @(posedge core_clk_in);
        end
    endtask
    task first_pulse;
        begin
            run(252);
            check(line_freq_out, 0, "line early");
            run(4);
            repeat (4) @(posedge core_clk_in);
            check(line_freq_out, 1, "line first");
        end
    endtask
    task test_switch;
        begin
            first_pulse;
            sel_60hz_in <= 1'b0;
            repeat (5) @(posedge core_clk_in);
            check({line_freq_out, ten_hz_out, one_hz_out}, 3, "restart");
            first_pulse;
            $display("switch test done");
        end
    endtask
    task test_hold;
        begin
            sel_float_in <= 1'b1;
            run(300);
            check({line_freq_out, ten_hz_out, one_hz_out}, 3, "held");
            check(hold_active_out, 1, "hold on");
            sel_float_in <= 1'b0;
            repeat (3) @(posedge core_clk_in);
            check(hold_active_out, 0, "hold off");
            first_pulse;
            $display("hold test done");
        end
    endtask
    task measure(input m60, input integer n, el, et, eo, lo, hi);
        integer l0, t0, o0, h0, g0, c0, pct;
        begin
            half_q <= 4'h1;
            sel_float_in <= 1'b1;
            sel_60hz_in <= m60;
            repeat (4) @(posedge core_clk_in);
            sel_float_in <= 1'b0;
            @(posedge core_clk_in);
            {l0, t0, o0, h0, g0, c0} = {lt, tt, ot, th, oh, cyc};
            run(n);
            run_q <= 1'b0;
            repeat (8) @(posedge core_clk_in);
            check(lt - l0, el, "line toggles");
            check(tt - t0, et, "ten toggles");
            check(ot - o0, eo, "one toggles");
            pct = (th - h0) * 100 / (cyc - c0);
            check(pct >= lo && pct <= hi, 1, "ten duty");
            pct = (oh - g0) * 100 / (cyc - c0);
            if (m60)
                check(pct >= 45 && pct <= 55, 1, "one duty");
            $display("rate test done, mode60 %0d", m60);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d, mismatches %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        repeat (105000) @(posedge core_clk_in);
        error_cnt = error_cnt + 1;
        test_done;
    end
    initial begin
        repeat (10) @(posedge core_clk_in);
        check({line_freq_out, ten_hz_out, one_hz_out, hold_active_out}, 6, "reset");
        rst_in <= 1'b0;
        test_switch;
        test_hold;
        measure(1'b1, 32768, 120, 20, 2, 45, 55);
        measure(1'b0, 16384, 50, 10, 1, 36, 44);
        test_done;
    end
endmodule
